//--- logic/lpm_pkg.sv
// Package with the register map, field layout and states of the low-power mode controller.
package lpm_pkg;
  localparam logic [7:0] OFF_STBY  = 8'h00;
  localparam logic [7:0] OFF_DEEP  = 8'h04;
  localparam logic [7:0] OFF_SNZ   = 8'h08;
  localparam logic [7:0] OFF_LEVEL = 8'h0C;
  localparam logic [7:0] OFF_REG   = 8'h10;
  localparam logic [7:0] OFF_DIV   = 8'h14;
  localparam logic [7:0] OFF_MSTOP = 8'h18;
  localparam logic [7:0] OFF_WAKE  = 8'h1C;
  localparam logic [7:0] OFF_SNSRC = 8'h20;
  localparam logic [7:0] OFF_STAT  = 8'h24;

  // Power level codes.
  localparam logic [2:0] LVL_HIGH   = 3'h0;
  localparam logic [2:0] LVL_MID    = 3'h1;
  localparam logic [2:0] LVL_LOW    = 3'h2;
  localparam logic [2:0] LVL_LOWV   = 3'h3;
  localparam logic [2:0] LVL_SUBOSC = 3'h4;
  localparam logic [2:0] LVL_RST    = 3'h0;

  // Divider field layout: five 4-bit codes.
  localparam int DIV_W      = 4;
  localparam int DIV_SYS    = 0;
  localparam int DIV_PERIPHERAL_CLOCK_B  = 4;
  localparam int DIV_PERIPHERAL_CLOCK_D  = 8;
  localparam int DIV_CLOCK_OUTPUT = 12;
  localparam int DIV_FLASH  = 16;
  localparam logic [19:0] DIV_RST = 20'h0_0000;

  // Status register bit positions.
  localparam int ST_STATE  = 0;
  localparam int ST_SW     = 2;
  localparam int ST_RFSTBY = 3;
  localparam int ST_RFREG  = 4;
  localparam int ST_RFLVL  = 5;

  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_SLEEP,
    ST_STANDBY,
    ST_SNOOZE
  } lpm_state_t;
endpackage

//--- logic/lpm_ctrl.sv
// Low-power mode controller with its APB register file.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/100ps

module lpm_ctrl #(
  parameter int NIRQ     = 16,
  parameter int NMOD     = 16,
  parameter bit HAS_LOWV = 1'b0
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // APB slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic                 pready,
  output logic                 pslverr,
  output logic [31:0]          prdata,
  // Core and wake events
  input  wire logic            wfiReq,
  input  wire logic [NIRQ-1:0] irqPend,
  input  wire logic            nmiPend,
  input  wire logic            snoozeTrigPin,
  input  wire logic            snoozeDone,
  // Controls out
  output logic [1:0]           lpState,
  output logic                 cpuClkStop,
  output logic                 periphClkStop,
  output logic                 wakeIrq,
  output logic [2:0]           powerLevel,
  output logic                 switchingRegulatorMode,
  output logic [19:0]          clkDiv,
  output logic [NMOD-1:0]      moduleStop,
  output logic                 hocoAvail,
  output logic                 mocoAvail,
  output logic                 mainOscAvail
);
  lpm_pkg::lpm_state_t st_q;
  logic                standbySelect_q;
  logic                deepStandbySelect_q;
  logic                snoozeEnable_q;
  logic [2:0]          level_q;
  logic                sw_q;
  logic [19:0]         div_q;
  logic [NMOD-1:0]     mstop_q;
  logic [NIRQ-1:0]     wakeEn_q;
  logic [NIRQ-1:0]     snzSrc_q;
  logic                rfStby_q;
  logic                rfReg_q;
  logic                rfLvl_q;
  logic                trigMeta_q;
  logic                trigSync_q;
  logic                rdy_q;
  logic                err_q;
  logic [31:0]         rdat_q;
  logic                wake_q;
  logic                wr;
  logic                wakeSleep;
  logic                wakeStby;
  logic                wakeSnz;
  logic                refuseStby;
  logic                refuseReg;
  logic                refuseLvl;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= lpm_pkg::OFF_STAT) && (a[1:0] == 2'b00);
  endfunction

  // A level is legal if the variant has it and the regulator mode allows it.
  function automatic logic levelOk(input logic [2:0] l, input logic sw);
    if (sw)
      levelOk = (l == lpm_pkg::LVL_HIGH) || (l == lpm_pkg::LVL_MID);
    else
      levelOk = (l == lpm_pkg::LVL_HIGH) || (l == lpm_pkg::LVL_MID)
             || (l == lpm_pkg::LVL_LOW) || (l == lpm_pkg::LVL_SUBOSC)
             || ((l == lpm_pkg::LVL_LOWV) && HAS_LOWV);
  endfunction

  assign wr = psel && penable && rdy_q && pwrite;
  assign wakeSleep = (|irqPend) || nmiPend;
  assign wakeStby = (|(irqPend & wakeEn_q)) || nmiPend;
  assign wakeSnz = (|(irqPend & wakeEn_q & snzSrc_q)) || nmiPend;
  assign refuseStby = (st_q == lpm_pkg::ST_NORMAL) && wfiReq && standbySelect_q
                   && (deepStandbySelect_q || sw_q);
  // Entry is also refused in Standby or Snooze, which switching mode cannot hold.
  assign refuseReg = wr && (paddr == lpm_pkg::OFF_REG) && pwdata[0] && !sw_q
                  && (!levelOk(level_q, 1'b1) || (st_q == lpm_pkg::ST_STANDBY)
                      || (st_q == lpm_pkg::ST_SNOOZE));
  assign refuseLvl = wr && (paddr == lpm_pkg::OFF_LEVEL) && !levelOk(pwdata[2:0], sw_q);

  // The snooze trigger comes from a pin, so it is synchronised first.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      trigMeta_q <= 1'b0;
      trigSync_q <= 1'b0;
    end
    else
    begin
      trigMeta_q <= snoozeTrigPin;
      trigSync_q <= trigMeta_q;
    end
  end

  // APB answers with no wait state; data is captured in the setup cycle.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdy_q  <= 1'b0;
      err_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      rdy_q  <= psel && !penable;
      err_q  <= psel && !penable && !mapped(paddr);
      rdat_q <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          lpm_pkg::OFF_STBY:  rdat_q[0] <= standbySelect_q;
          lpm_pkg::OFF_DEEP:  rdat_q[0] <= deepStandbySelect_q;
          lpm_pkg::OFF_SNZ:   rdat_q[0] <= snoozeEnable_q;
          lpm_pkg::OFF_LEVEL: rdat_q[2:0] <= level_q;
          lpm_pkg::OFF_REG:   rdat_q[0] <= sw_q;
          lpm_pkg::OFF_DIV:   rdat_q[19:0] <= div_q;
          lpm_pkg::OFF_MSTOP: rdat_q[NMOD-1:0] <= mstop_q;
          lpm_pkg::OFF_WAKE:  rdat_q[NIRQ-1:0] <= wakeEn_q;
          lpm_pkg::OFF_SNSRC: rdat_q[NIRQ-1:0] <= snzSrc_q;
          lpm_pkg::OFF_STAT:
          begin
            rdat_q[lpm_pkg::ST_STATE+:2] <= st_q;
            rdat_q[lpm_pkg::ST_SW]       <= sw_q;
            rdat_q[lpm_pkg::ST_RFSTBY]   <= rfStby_q;
            rdat_q[lpm_pkg::ST_RFREG]    <= rfReg_q;
            rdat_q[lpm_pkg::ST_RFLVL]    <= rfLvl_q;
          end
          default:            rdat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control registers; every reset brings back Normal-run defaults.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      standbySelect_q     <= 1'b0;
      deepStandbySelect_q <= 1'b0;
      snoozeEnable_q      <= 1'b0;
      level_q             <= lpm_pkg::LVL_RST;
      div_q               <= lpm_pkg::DIV_RST;
      mstop_q             <= '0;
      wakeEn_q            <= '0;
      snzSrc_q            <= '0;
    end
    else if (wr)
    begin
      unique case (paddr)
        lpm_pkg::OFF_STBY:  standbySelect_q <= pwdata[0];
        lpm_pkg::OFF_DEEP:  deepStandbySelect_q <= pwdata[0];
        lpm_pkg::OFF_SNZ:   snoozeEnable_q <= pwdata[0];
        lpm_pkg::OFF_LEVEL:
          if (!refuseLvl)
            level_q <= pwdata[2:0];
        lpm_pkg::OFF_DIV:   div_q <= pwdata[19:0];
        lpm_pkg::OFF_MSTOP: mstop_q <= pwdata[NMOD-1:0];
        lpm_pkg::OFF_WAKE:  wakeEn_q <= pwdata[NIRQ-1:0];
        lpm_pkg::OFF_SNSRC: snzSrc_q <= pwdata[NIRQ-1:0];
        default:            ;
      endcase
    end
  end

  // Regulator mode; leaving switching mode is always allowed.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sw_q <= 1'b0;
    else if (wr && (paddr == lpm_pkg::OFF_REG) && !refuseReg)
      sw_q <= pwdata[0];
  end

  // Sticky refusal flags; a new refusal wins over a write-one clear.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rfStby_q <= 1'b0;
      rfReg_q  <= 1'b0;
      rfLvl_q  <= 1'b0;
    end
    else
    begin
      rfStby_q <= refuseStby
               || (rfStby_q && !(wr && (paddr == lpm_pkg::OFF_STAT) && pwdata[lpm_pkg::ST_RFSTBY]));
      rfReg_q  <= refuseReg
               || (rfReg_q && !(wr && (paddr == lpm_pkg::OFF_STAT) && pwdata[lpm_pkg::ST_RFREG]));
      rfLvl_q  <= refuseLvl
               || (rfLvl_q && !(wr && (paddr == lpm_pkg::OFF_STAT) && pwdata[lpm_pkg::ST_RFLVL]));
    end
  end

  // Mode sequencer; a reset from any state lands in Normal via rst_n.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q   <= lpm_pkg::ST_NORMAL;
      wake_q <= 1'b0;
    end
    else
    begin
      wake_q <= 1'b0;
      unique case (st_q)
        lpm_pkg::ST_NORMAL:
          if (wfiReq && !standbySelect_q)
            st_q <= lpm_pkg::ST_SLEEP;
          else if (wfiReq && !deepStandbySelect_q && !sw_q)
            st_q <= lpm_pkg::ST_STANDBY;
        lpm_pkg::ST_SLEEP:
          if (wakeSleep)
          begin
            st_q   <= lpm_pkg::ST_NORMAL;
            wake_q <= 1'b1;
          end
        lpm_pkg::ST_STANDBY:
          if (wakeStby)
          begin
            st_q   <= lpm_pkg::ST_NORMAL;
            wake_q <= 1'b1;
          end
          else if (trigSync_q && snoozeEnable_q)
            st_q <= lpm_pkg::ST_SNOOZE;
        lpm_pkg::ST_SNOOZE:
          if (wakeSnz)
          begin
            st_q   <= lpm_pkg::ST_NORMAL;
            wake_q <= 1'b1;
          end
          else if (snoozeDone)
            st_q <= lpm_pkg::ST_STANDBY;
      endcase
    end
  end

  // Output flops; clock gating follows the state, oscillators the level.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lpState                <= 2'b00;
      cpuClkStop             <= 1'b0;
      periphClkStop          <= 1'b0;
      powerLevel             <= lpm_pkg::LVL_RST;
      switchingRegulatorMode <= 1'b0;
      clkDiv                 <= lpm_pkg::DIV_RST;
      moduleStop             <= '0;
      hocoAvail              <= 1'b1;
      mocoAvail              <= 1'b1;
      mainOscAvail           <= 1'b1;
    end
    else
    begin
      lpState                <= st_q;
      cpuClkStop             <= (st_q != lpm_pkg::ST_NORMAL);
      periphClkStop          <= (st_q == lpm_pkg::ST_STANDBY);
      powerLevel             <= level_q;
      switchingRegulatorMode <= sw_q;
      clkDiv                 <= div_q;
      moduleStop             <= mstop_q;
      hocoAvail              <= (level_q != lpm_pkg::LVL_SUBOSC);
      mocoAvail              <= (level_q != lpm_pkg::LVL_SUBOSC);
      mainOscAvail           <= (level_q != lpm_pkg::LVL_SUBOSC);
    end
  end

  assign pready  = rdy_q;
  assign pslverr = err_q;
  assign prdata  = rdat_q;
  assign wakeIrq = wake_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_sleepEntry;
    st_q == lpm_pkg::ST_NORMAL && wfiReq && !standbySelect_q |=> st_q == lpm_pkg::ST_SLEEP;
  endproperty
  a_sleepEntry: assert property (p_sleepEntry) else $error("no sleep entry");

  property p_stbyEntry;
    st_q == lpm_pkg::ST_NORMAL && wfiReq && standbySelect_q && !deepStandbySelect_q && !sw_q
      |=> st_q == lpm_pkg::ST_STANDBY;
  endproperty
  a_stbyEntry: assert property (p_stbyEntry) else $error("no standby entry");

  property p_noStbyInSw;
    sw_q |-> st_q != lpm_pkg::ST_STANDBY && st_q != lpm_pkg::ST_SNOOZE;
  endproperty
  a_noStbyInSw: assert property (p_noStbyInSw) else $error("standby in switching mode");

  property p_swLevel;
    sw_q |-> level_q == lpm_pkg::LVL_HIGH || level_q == lpm_pkg::LVL_MID;
  endproperty
  a_swLevel: assert property (p_swLevel) else $error("bad level in switching mode");

  property p_snzSource;
    $rose(st_q == lpm_pkg::ST_SNOOZE) |-> $past(st_q) == lpm_pkg::ST_STANDBY
      && $past(snoozeEnable_q);
  endproperty
  a_snzSource: assert property (p_snzSource) else $error("snooze from wrong state");

  property p_sleepWake;
    st_q == lpm_pkg::ST_SLEEP && wakeSleep |=> st_q == lpm_pkg::ST_NORMAL && wakeIrq;
  endproperty
  a_sleepWake: assert property (p_sleepWake) else $error("sleep not ended");

  property p_stbyHold;
    st_q == lpm_pkg::ST_STANDBY && !wakeStby |=> st_q != lpm_pkg::ST_NORMAL;
  endproperty
  a_stbyHold: assert property (p_stbyHold) else $error("standby left without wake");

  property p_wakeCause;
    wakeIrq |-> $past(st_q) != lpm_pkg::ST_NORMAL && st_q == lpm_pkg::ST_NORMAL;
  endproperty
  a_wakeCause: assert property (p_wakeCause) else $error("stray wake pulse");

  property p_rstDefault;
    disable iff (1'b0) !rst_n |=> st_q == lpm_pkg::ST_NORMAL && !standbySelect_q
      && !snoozeEnable_q && level_q == lpm_pkg::LVL_RST;
  endproperty
  a_rstDefault: assert property (p_rstDefault) else $error("reset defaults wrong");

  property p_subosc;
    level_q == lpm_pkg::LVL_SUBOSC |=> !hocoAvail && !mocoAvail && !mainOscAvail;
  endproperty
  a_subosc: assert property (p_subosc) else $error("oscillator left on");
endmodule

//--- tb/lpm_core_model.sv
// Model of the processor core that issues wait-for-interrupt and raises wake events.
`timescale 1ns/100ps
module lpm_core_model (
  // Clock
  input  wire logic clk,
  // Toward the controller
  output logic        wfiReq,
  output logic [15:0] irqPend,
  output logic        nmiPend,
  output logic        snoozeTrigPin,
  output logic        snoozeDone
);
  initial
  begin
    wfiReq = 1'b0;
    irqPend = 16'h0000;
    nmiPend = 1'b0;
    snoozeTrigPin = 1'b0;
    snoozeDone = 1'b0;
  end

  // The instruction is a single-cycle pulse; software sets the select bits before it.
  task automatic wfi();
    @(posedge clk);
    wfiReq <= 1'b1;
    @(posedge clk);
    wfiReq <= 1'b0;
  endtask

  task automatic irq(input logic [15:0] v, input logic n);
    @(posedge clk);
    irqPend <= v;
    nmiPend <= n;
  endtask

  task automatic trig(input logic t);
    @(posedge clk);
    snoozeTrigPin <= t;
  endtask

  task automatic done(input logic d);
    @(posedge clk);
    snoozeDone <= d;
  endtask
endmodule

//--- tb/low_power_mode_controller_tb.sv
// Self-checking testbench for the low-power mode controller.
`timescale 1ns/100ps
module low_power_mode_controller_tb;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready, pslverr, wfiReq, nmiPend, trigPin, snzDone;
  logic [31:0] prdata, q;
  logic [15:0] irqPend, moduleStop;
  logic [1:0]  lpState;
  logic [2:0]  powerLevel;
  logic [19:0] clkDiv;
  logic        cpuClkStop, periphClkStop, wakeIrq, swMode, hoco, moco, mainOsc, err;
  logic [2:0]  lv [3] = '{lpm_pkg::LVL_MID, lpm_pkg::LVL_LOW, lpm_pkg::LVL_SUBOSC};
  int          mismatches = 0;
  int          nTests = 0;

  always #2 clk = ~clk;

  lpm_core_model core (.clk(clk), .wfiReq(wfiReq), .irqPend(irqPend), .nmiPend(nmiPend),
    .snoozeTrigPin(trigPin), .snoozeDone(snzDone));

  lpm_ctrl #(.NIRQ(16), .NMOD(16), .HAS_LOWV(1'b0)) dut (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .wfiReq(wfiReq),
    .irqPend(irqPend), .nmiPend(nmiPend), .snoozeTrigPin(trigPin), .snoozeDone(snzDone),
    .lpState(lpState), .cpuClkStop(cpuClkStop), .periphClkStop(periphClkStop),
    .wakeIrq(wakeIrq), .powerLevel(powerLevel), .switchingRegulatorMode(swMode),
    .clkDiv(clkDiv), .moduleStop(moduleStop), .hocoAvail(hoco), .mocoAvail(moco),
    .mainOscAvail(mainOsc));

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic giveUp(input string what);
    chk(what, 32'h0000_0000, 32'h0000_0001);
    complete_run();
  endtask

  // Request is held from setup until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      giveUp("pready wait");
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk($sformatf("read %h", a), q & mask, exp);
  endtask

  task automatic waitState(input logic [1:0] s);
    int n;
    for (n = 0; n < 20 && lpState !== s; n++)
      @(posedge clk);
    if (n >= 20)
      giveUp("state wait");
  endtask

  task automatic waitWake();
    int n;
    for (n = 0; n < 20 && wakeIrq !== 1'b1; n++)
      @(posedge clk);
    if (n >= 20)
      giveUp("wake pulse");
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("state", lpState, 2'd0);
    chk("osc avail", {hoco, moco, mainOsc}, 3'b111);
    rdChk(lpm_pkg::OFF_LEVEL, 32'hFFFF_FFFF, 32'h0000_0000);
    rdChk(8'h28, 32'hFFFF_FFFF, 32'h0000_0000);
    chk("pslverr", err, 1'b1);
    apb(1'b1, lpm_pkg::OFF_DIV, 32'h0005_4321);
    apb(1'b1, lpm_pkg::OFF_MSTOP, 32'h0000_A5C3);
    rdChk(lpm_pkg::OFF_DIV, 32'hFFFF_FFFF, 32'h0005_4321);
    chk("clkDiv", clkDiv, 20'h5_4321);
    chk("moduleStop", moduleStop, 16'hA5C3);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, lpm_pkg::OFF_LEVEL, {29'h0, lv[i]});
      rdChk(lpm_pkg::OFF_LEVEL, 32'h0000_0007, {29'h0, lv[i]});
      chk("powerLevel", powerLevel, lv[i]);
      chk("osc", {hoco, moco, mainOsc}, (i == 2) ? 3'b000 : 3'b111);
    end
    apb(1'b1, lpm_pkg::OFF_LEVEL, {29'h0, lpm_pkg::LVL_LOWV});
    rdChk(lpm_pkg::OFF_LEVEL, 32'h0000_0007, {29'h0, lpm_pkg::LVL_SUBOSC});
    apb(1'b1, lpm_pkg::OFF_STAT, 32'h0000_0038);
    apb(1'b1, lpm_pkg::OFF_LEVEL, {29'h0, lpm_pkg::LVL_LOW});
    apb(1'b1, lpm_pkg::OFF_REG, 32'h0000_0001);
    rdChk(lpm_pkg::OFF_REG, 32'h0000_0001, 32'h0000_0000);
    rdChk(lpm_pkg::OFF_STAT, 32'h0000_0038, 32'h0000_0010);
    apb(1'b1, lpm_pkg::OFF_STAT, 32'h0000_0038);
    apb(1'b1, lpm_pkg::OFF_LEVEL, {29'h0, lpm_pkg::LVL_HIGH});
    apb(1'b1, lpm_pkg::OFF_REG, 32'h0000_0001);
    apb(1'b1, lpm_pkg::OFF_LEVEL, {29'h0, lpm_pkg::LVL_LOW});
    chk("switching", swMode, 1'b1);
    rdChk(lpm_pkg::OFF_LEVEL, 32'h0000_0007, {29'h0, lpm_pkg::LVL_HIGH});
    rdChk(lpm_pkg::OFF_STAT, 32'h0000_0038, 32'h0000_0020);
    apb(1'b1, lpm_pkg::OFF_STAT, 32'h0000_0038);
    apb(1'b1, lpm_pkg::OFF_STBY, 32'h0000_0001);
    core.wfi();
    repeat (4) @(posedge clk);
    chk("refused standby", lpState, 2'd0);
    rdChk(lpm_pkg::OFF_STAT, 32'h0000_0038, 32'h0000_0008);
    apb(1'b1, lpm_pkg::OFF_STBY, 32'h0000_0000);
    core.wfi();
    waitState(2'd1);
    chk("cpu clock stop", cpuClkStop, 1'b1);
    core.irq(16'h0100, 1'b0);
    waitWake();
    waitState(2'd0);
    core.irq(16'h0000, 1'b0);
    apb(1'b1, lpm_pkg::OFF_REG, 32'h0000_0000);
    apb(1'b1, lpm_pkg::OFF_STBY, 32'h0000_0001);
    apb(1'b1, lpm_pkg::OFF_WAKE, 32'h0000_0002);
    core.wfi();
    waitState(2'd2);
    chk("periph clock stop", periphClkStop, 1'b1);
    core.irq(16'h0001, 1'b0);
    repeat (6) @(posedge clk);
    chk("masked wake", lpState, 2'd2);
    core.irq(16'h0003, 1'b0);
    waitWake();
    waitState(2'd0);
    core.irq(16'h0000, 1'b0);
    core.trig(1'b1);
    repeat (6) @(posedge clk);
    chk("trigger in normal", lpState, 2'd0);
    core.trig(1'b0);
    apb(1'b1, lpm_pkg::OFF_SNZ, 32'h0000_0001);
    apb(1'b1, lpm_pkg::OFF_SNSRC, 32'h0000_0002);
    core.wfi();
    waitState(2'd2);
    core.trig(1'b1);
    waitState(2'd3);
    core.trig(1'b0);
    core.irq(16'h0001, 1'b0);
    repeat (6) @(posedge clk);
    chk("snooze masked", lpState, 2'd3);
    core.done(1'b1);
    waitState(2'd2);
    core.done(1'b0);
    chk("back in standby", periphClkStop, 1'b1);
    core.trig(1'b1);
    waitState(2'd3);
    core.trig(1'b0);
    core.irq(16'h0000, 1'b1);
    waitWake();
    waitState(2'd0);
    core.irq(16'h0000, 1'b0);
    apb(1'b1, lpm_pkg::OFF_STBY, 32'h0000_0000);
    core.wfi();
    waitState(2'd1);
    apb(1'b1, lpm_pkg::OFF_STBY, 32'h0000_0001);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("reset wake", {lpState, wakeIrq}, 3'b000);
    rdChk(lpm_pkg::OFF_SNZ, 32'hFFFF_FFFF, 32'h0000_0000);
    rdChk(lpm_pkg::OFF_STBY, 32'hFFFF_FFFF, 32'h0000_0000);
    complete_run();
  end
endmodule
